// [bench/iecd_core_chk.sv]
// Purpose: Port-level checks for the instruction executor
// Assumes: ahbReq.hready is the bus hready, fed from hreadyout
// Notes: Opcode is read off hwdata in the first data cycle of an instruction write
`timescale 1ns/1ns
module iecd_core_chk
   import iecd_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Bus side
   input iecd_pkg::iecd_ahb_req_t ahbReq,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Core side
   input wire logic [12:0] pcOut,
   input wire logic [7:0] wregOut,
   input wire logic skipOut
);
   logic dpFirst;
   logic [12:0] pcStart;
   // Instruction write accepted in its address phase
   wire logic instrTake = ahbReq.hsel && ahbReq.htrans == 2'h2 && ahbReq.hwrite
      && ahbReq.haddr == 32'h00000000 && ahbReq.hready;
   // Opcode classes, valid only while dpFirst is high
   wire logic isCall = hwdata[13:11] == 3'h4;
   wire logic isDskz = hwdata[13:8] == 6'h0B;
   wire logic isClrw = hwdata[13:7] == 7'h02;
   wire logic isDecfF = hwdata[13:8] == 6'h03 && hwdata[7];
   wire logic isShort = !isCall && !isDskz;
   // First data cycle and the program counter seen there
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dpFirst <= 1'b0;
         pcStart <= 13'h0000;
      end
      else
      begin
         dpFirst <= instrTake;
         if (dpFirst)
            pcStart <= pcOut;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Wait-state shapes of long and short instructions
   sequence longWait;
      !hreadyout [*3] ##1 hreadyout;
   endsequence
   sequence shortWait;
      !hreadyout [*2] ##1 hreadyout;
   endsequence
   chk_resp_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
   chk_call_cycles: assert property (dpFirst && isCall |-> longWait) else $error("call length wrong");
   chk_short_cycles: assert property (dpFirst && isShort |-> shortWait) else $error("op length wrong");
   chk_short_noskip: assert property (dpFirst && isShort |-> ##2 !skipOut) else $error("skip flagged");
   chk_call_target: assert property (dpFirst && isCall |-> ##3 pcOut[10:0] == $past(hwdata[10:0], 3))
      else $error("call target wrong");
   chk_clear_working_op_zero: assert property (dpFirst && isClrw |-> ##2 wregOut == 8'h00) else $error("w not cleared");
   chk_dest_file: assert property (dpFirst && isDecfF |-> ##2 $stable(wregOut)) else $error("w overwritten");
   chk_skip_not: assert property (dpFirst && isDskz ##2 hreadyout |-> !skipOut && pcOut == pcStart + 13'h1)
      else $error("untaken skip wrong");
   chk_skip_taken: assert property (dpFirst && isDskz ##2 !hreadyout |->
      ##1 hreadyout && skipOut && pcOut == pcStart + 13'h2) else $error("taken skip wrong");
endmodule : iecd_core_chk
bind iecd_core iecd_core_chk i_chk (.mclk(mclk), .rst_n(rst_n), .ahbReq(ahbReq), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pcOut(pcOut), .wregOut(wregOut), .skipOut(skipOut));

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the instruction executor
// Assumes: One AHB-Lite master, single word transfers
// Notes: File cell 5 sits at window byte 0x94
`timescale 1ns/1ns
`include "iecd_map.svh"
module tb_top;
   import iecd_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   iecd_ahb_req_t rq;
   iecd_ahb_req_t ahbReq;
   logic [31:0] hwdata, hrdata, rd;
   logic hreadyout, hresp, skipOut;
   logic [12:0] pcOut, p;
   logic [7:0] wregOut;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   // Single slave, so its hreadyout is the bus hready
   assign ahbReq = {rq[39:1], hreadyout};
   iecd_core i_dut (.mclk(mclk), .rst_n(rst_n), .ahbReq(ahbReq), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pcOut(pcOut), .wregOut(wregOut), .skipOut(skipOut));
   // Clock and hang guard
   always #5 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         bad_count++;
         final_report();
      end
   end
   task final_report;
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report
   task check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Address phase held until hready, then data phase held until hready
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      rq.hsel <= 1'b1;
      rq.haddr <= a;
      rq.htrans <= 2'h2;
      rq.hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rq.hsel <= 1'b0;
      rq.htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task rc(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd, e);
   endtask : rc
   task ex(input logic [13:0] op);
      bus(1'b1, `IECD_OFF_INSTR, {18'h0, op});
   endtask : ex
   task t_wdog;
      rc(`IECD_OFF_STATUS, 32'h18);
      rc(32'h40, 32'h0);
      bus(1'b1, `IECD_OFF_STATUS, 32'h0);
      ex(14'h0064);
      // Cleared counter then free-runs three clocks before the read samples it
      rc(`IECD_OFF_WDOG, 32'h3);
      rc(`IECD_OFF_STATUS, 32'h18);
   endtask : t_wdog
   task t_file;
      bus(1'b1, 32'h94, 32'h1);
      ex(14'h0385);
      rc(32'h94, 32'h0);
      rc(`IECD_OFF_STATUS, 32'h1C);
      ex(14'h0305);
      rc(`IECD_OFF_WREG, 32'hFF);
      rc(`IECD_OFF_STATUS, 32'h18);
      ex(14'h0985);
      rc(32'h94, 32'hFF);
      ex(14'h0905);
      rc(`IECD_OFF_WREG, 32'h0);
      rc(`IECD_OFF_STATUS, 32'h1C);
      ex(14'h0305);
      ex(14'h0185);
      rc(32'h94, 32'h0);
      rc(`IECD_OFF_STATUS, 32'h1C);
      ex(14'h0905);
      ex(14'h0100);
      rc(`IECD_OFF_WREG, 32'h0);
      rc(`IECD_OFF_STATUS, 32'h1C);
   endtask : t_file
   // Untaken then taken skip with the zero flag clear, then an untaken skip with it set
   task t_skip;
      bus(1'b1, 32'h94, 32'h2);
      ex(14'h0905);
      bus(1'b0, `IECD_OFF_PC, 32'h0);
      p = rd[12:0];
      ex(14'h0B85);
      rc(32'h94, 32'h1);
      check({31'h0, skipOut}, 32'h0);
      rc(`IECD_OFF_PC, {19'h0, p + 13'h1});
      ex(14'h0B05);
      rc(`IECD_OFF_WREG, 32'h0);
      rc(`IECD_OFF_STATUS, 32'h18);
      check({31'h0, skipOut}, 32'h1);
      rc(`IECD_OFF_PC, {19'h0, p + 13'h3});
      bus(1'b1, 32'h94, 32'h3);
      ex(14'h0100);
      ex(14'h0B85);
      rc(`IECD_OFF_STATUS, 32'h1C);
   endtask : t_skip
   // Both high latch bits, then one, against full and small literals
   task t_call;
      bus(1'b1, `IECD_OFF_LATCH, 32'h18);
      bus(1'b0, `IECD_OFF_PC, 32'h0);
      p = rd[12:0];
      ex(14'h27FF);
      rc(`IECD_OFF_PC, 32'h1FFF);
      bus(1'b0, `IECD_OFF_STACK, 32'h0);
      check({19'h0, rd[12:0]}, {19'h0, p + 13'h1});
      check({29'h0, rd[18:16]}, 32'h1);
      bus(1'b1, `IECD_OFF_LATCH, 32'h08);
      ex(14'h2005);
      rc(`IECD_OFF_PC, 32'h0805);
   endtask : t_call
   // Reset, then the scenarios in turn
   initial
   begin
      rq = '0;
      rq.hsize = 3'h2;
      hwdata = 32'h0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_wdog();
      t_file();
      t_skip();
      t_call();
      final_report();
   end
endmodule : tb_top

// [logic/iecd_core.sv]
// Purpose: Executes clear-watchdog, call, complement, clear, decrement and skip ops
// Assumes: Software writes one instruction word at a time over AHB-Lite
// Notes: Two-cycle ops hold the bus with hreadyout low for the second cycle
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "iecd_map.svh"
module iecd_core
   import iecd_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // AHB-Lite slave
   input iecd_pkg::iecd_ahb_req_t ahbReq,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Core observation
   output logic [12:0] pcOut,
   output logic [7:0] wregOut,
   output logic skipOut
);
   import iecd_pkg::*;

   // Reset release through two flops
   logic rstMeta_reg;
   logic rstSync_reg;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end
      else
      begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end
   wire logic rstN = rstSync_reg;

   // Architectural state
   logic [7:0] fileMem [0:127];
   logic [12:0] stackMem [0:`IECD_STACK_DEPTH-1];
   logic [2:0] sp_reg;
   logic [12:0] pc_reg;
   logic [7:0] wreg_reg;
   logic [7:0] status_reg;
   logic [7:0] latch_reg;
   logic [7:0] wdog_reg;
   logic [7:0] presc_reg;
   logic [13:0] instr_reg;
   logic skip_reg;
   logic [31:0] rdata_reg;
   logic ready_reg;
   iecd_state_t state_reg;

   // Address phase capture
   logic wrPend_reg;
   logic rdPend_reg;
   logic [7:0] addr_reg;
   wire logic accept = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;

   // Register address match used for both read mux and write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // Decode of the pending instruction
   iecd_dec_t dec;
   iecd_decode uDec
   (
      .instr(instr_reg),
      .dec(dec)
   );

   // Datapath for file ops
   wire logic [7:0] fVal = fileMem[dec.fileAddr];
   wire logic [7:0] decRes = fVal - 8'h01;
   wire logic [7:0] comRes = ~fVal;
   wire logic [7:0] res = dec.complement_file_op ? comRes : (dec.clear_file_op ? 8'h00 : decRes);
   wire logic fileOp = dec.complement_file_op | dec.decrement_file_op | dec.dskz | dec.clear_file_op;
   wire logic toFile = dec.clear_file_op | ((dec.complement_file_op | dec.decrement_file_op | dec.dskz) & dec.dest);
   wire logic toW = (dec.complement_file_op | dec.decrement_file_op | dec.dskz) & ~dec.dest;
   wire logic zeroRes = (res == 8'h00);
   wire logic skipTaken = dec.dskz & (decRes == 8'h00);
   wire logic longOp = dec.call | skipTaken;
   wire logic execNow = (state_reg == IECD_EXEC);
   wire logic [12:0] callTarget = {latch_reg[4:3], dec.lit};

   // Bus sequencing: execute on write to instruction word, stall on long ops
   wire logic wrInstr = wrPend_reg & hit(addr_reg, `IECD_OFF_INSTR);
   iecd_state_t state_next;
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         IECD_IDLE: if (wrInstr) state_next = IECD_EXEC;
         IECD_EXEC: state_next = longOp ? IECD_SECOND : IECD_IDLE;
         IECD_SECOND: state_next = IECD_IDLE;
         default: state_next = IECD_IDLE;
      endcase
   end

   // Bus phase tracking
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         wrPend_reg <= 1'b0;
         rdPend_reg <= 1'b0;
         addr_reg <= 8'h00;
         ready_reg <= 1'b1;
         state_reg <= IECD_IDLE;
      end
      else
      begin
         wrPend_reg <= accept & ahbReq.hwrite;
         rdPend_reg <= accept & ~ahbReq.hwrite;
         if (accept)
            addr_reg <= ahbReq.haddr[7:0];
         state_reg <= state_next;
         // Hold ready low across execution so back-to-back writes see the result
         // Reads take one wait state so hrdata can come straight from a flop
         ready_reg <= (state_next == IECD_IDLE) && !(accept && (!ahbReq.hwrite
            || ahbReq.haddr[7:0] == `IECD_OFF_INSTR));
      end
   end

   // Instruction latch
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
         instr_reg <= `IECD_NOP;
      else if (wrInstr && state_reg == IECD_IDLE)
         instr_reg <= hwdata[13:0];
   end

   // Program counter, stack and skip handling
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         pc_reg <= `IECD_PC_RST;
         sp_reg <= 3'h0;
         skip_reg <= 1'b0;
      end
      else if (execNow)
      begin
         skip_reg <= skipTaken;
         if (dec.call)
         begin
            sp_reg <= sp_reg + 3'h1;
            pc_reg <= callTarget;
         end
         else
            pc_reg <= pc_reg + (skipTaken ? 13'h0002 : 13'h0001);
      end
      else if (wrPend_reg && hit(addr_reg, `IECD_OFF_PC) && state_reg == IECD_IDLE)
         pc_reg <= hwdata[12:0];
   end

   // Return stack push of the following address
   always_ff @(posedge mclk)
   begin
      if (execNow && dec.call)
         stackMem[sp_reg] <= pc_reg + 13'h0001;
   end

   // File memory: op writeback or direct window access
   wire logic memWin = addr_reg[7];
   always_ff @(posedge mclk)
   begin
      if (execNow && fileOp && toFile)
         fileMem[dec.fileAddr] <= res;
      else if (wrPend_reg && memWin && state_reg == IECD_IDLE)
         fileMem[{addr_reg[6:2], 2'b00} >> 2] <= hwdata[7:0];
   end

   // Working register, status, watchdog
   wire logic memWinWr = wrPend_reg && memWin && state_reg == IECD_IDLE;
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         wreg_reg <= 8'h00;
         status_reg <= `IECD_STATUS_RST;
         latch_reg <= 8'h00;
         wdog_reg <= 8'h00;
         presc_reg <= 8'h00;
      end
      else
      begin
         // Free-running watchdog so the clear has something to act on
         {wdog_reg, presc_reg} <= {wdog_reg, presc_reg} + 16'h0001;
         if (execNow)
         begin
            if (dec.clear_watchdog_op)
            begin
               wdog_reg <= 8'h00;
               presc_reg <= 8'h00;
               status_reg[`IECD_ST_TO_N] <= 1'b1;
               status_reg[`IECD_ST_PD_N] <= 1'b1;
            end
            if (dec.clear_working_op)
            begin
               wreg_reg <= 8'h00;
               status_reg[`IECD_ST_ZERO] <= 1'b1;
            end
            if (toW)
               wreg_reg <= res;
            // Decrement-skip leaves flags alone
            if (dec.complement_file_op | dec.decrement_file_op | dec.clear_file_op)
               status_reg[`IECD_ST_ZERO] <= zeroRes;
         end
         else if (wrPend_reg && state_reg == IECD_IDLE && !memWinWr)
         begin
            if (hit(addr_reg, `IECD_OFF_WREG))
               wreg_reg <= hwdata[7:0];
            if (hit(addr_reg, `IECD_OFF_STATUS))
               status_reg <= hwdata[7:0];
            if (hit(addr_reg, `IECD_OFF_LATCH))
               latch_reg <= hwdata[7:0];
         end
      end
   end

   // Read mux
   wire logic [7:0] memRd = fileMem[addr_reg[6:0] >> 2];
   wire logic [12:0] stackTop = stackMem[sp_reg - 3'h1];
   wire logic [31:0] rdMux =
      memWin ? {24'h000000, memRd} :
      hit(addr_reg, `IECD_OFF_INSTR) ? {18'h00000, instr_reg} :
      hit(addr_reg, `IECD_OFF_WREG) ? {24'h000000, wreg_reg} :
      hit(addr_reg, `IECD_OFF_STATUS) ? {24'h000000, status_reg} :
      hit(addr_reg, `IECD_OFF_PC) ? {19'h00000, pc_reg} :
      hit(addr_reg, `IECD_OFF_LATCH) ? {24'h000000, latch_reg} :
      hit(addr_reg, `IECD_OFF_STACK) ? {13'h0000, sp_reg, 3'h0, stackTop} :
      hit(addr_reg, `IECD_OFF_WDOG) ? {16'h0000, wdog_reg, presc_reg} : 32'h00000000;

   // Registered read data for the next cycle's data phase
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
         rdata_reg <= 32'h00000000;
      else if (accept && !ahbReq.hwrite)
         rdata_reg <= 32'h00000000;
      else if (rdPend_reg)
         rdata_reg <= rdMux;
   end

   assign hrdata = rdata_reg;
   assign hreadyout = ready_reg;
   assign hresp = 1'b0;
   assign pcOut = pc_reg;
   assign wregOut = wreg_reg;
   assign skipOut = skip_reg;
endmodule : iecd_core

// [logic/iecd_decode.sv]
// Purpose: Decodes one 14-bit instruction word into operation strobes
// Assumes: Unlisted codes decode to no operation
// Notes: Pure combinational
`timescale 1ns/1ns
`include "iecd_map.svh"
module iecd_decode
   import iecd_pkg::*;
(
   // Instruction in
   input wire logic [13:0] instr,
   // Decoded out
   output iecd_pkg::iecd_dec_t dec
);
   // Family selects compare the top three, six or seven bits
   assign dec.clear_watchdog_op = (instr == `IECD_OP_CWDT);
   assign dec.clear_working_op = (instr[13:7] == 7'h02);
   assign dec.clear_file_op = (instr[13:7] == `IECD_FAM_CLEAR_FILE_OP);
   assign dec.decrement_file_op = (instr[13:8] == `IECD_FAM_DECREMENT_FILE_OP);
   assign dec.complement_file_op = (instr[13:8] == `IECD_FAM_COMPLEMENT_FILE_OP);
   assign dec.dskz = (instr[13:8] == `IECD_FAM_DSKZ);
   assign dec.call = (instr[13:11] == `IECD_FAM_CALL);
   assign dec.dest = instr[7];
   assign dec.fileAddr = instr[6:0];
   assign dec.lit = instr[10:0];
endmodule : iecd_decode

// [logic/iecd_map.svh]
// Purpose: Constants for the clear/call/decrement instruction executor
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes: Offsets and timing counts for the register bus and the core
`ifndef IECD_MAP_SVH
`define IECD_MAP_SVH
// Register byte offsets
`define IECD_OFF_INSTR 8'h00
`define IECD_OFF_WREG 8'h04
`define IECD_OFF_STATUS 8'h08
`define IECD_OFF_PC 8'h0C
`define IECD_OFF_LATCH 8'h10
`define IECD_OFF_FILE 8'h14
`define IECD_OFF_STACK 8'h18
`define IECD_OFF_WDOG 8'h1C
`define IECD_OFF_MEMWIN 8'h80
// Status field positions
`define IECD_ST_ZERO 2
`define IECD_ST_PD_N 3
`define IECD_ST_TO_N 4
// Reset values
`define IECD_STATUS_RST 8'h18
`define IECD_PC_RST 13'h0000
// Opcode patterns (14-bit) and family prefixes (top 7, 6 or 3 bits)
`define IECD_OP_CWDT 14'h0064
`define IECD_OP_CLEAR_WORKING_OP 14'h0100
`define IECD_FAM_CLEAR_FILE_OP 7'h03
`define IECD_FAM_DECREMENT_FILE_OP 6'h03
`define IECD_FAM_COMPLEMENT_FILE_OP 6'h09
`define IECD_FAM_DSKZ 6'h0B
`define IECD_FAM_CALL 3'h4
`define IECD_NOP 14'h0000
// Timing: instruction cycle counts, then the return stack depth
`define IECD_CYC_LONG 2
`define IECD_STACK_DEPTH 8
`endif

// [logic/iecd_pkg.sv]
// Purpose: Types for the instruction executor
// Assumes: Widths written out in place; map header not included
// Notes: Structs carry bus and decode groups
package iecd_pkg;
   // AHB-Lite slave request group
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
   } iecd_ahb_req_t;
   // Decoded instruction
   typedef struct packed {
      logic clear_watchdog_op;
      logic call;
      logic complement_file_op;
      logic clear_file_op;
      logic decrement_file_op;
      logic clear_working_op;
      logic dskz;
      logic dest;
      logic [6:0] fileAddr;
      logic [10:0] lit;
   } iecd_dec_t;
   typedef enum logic [1:0] {
      IECD_IDLE = 2'b00,
      IECD_EXEC = 2'b01,
      IECD_SECOND = 2'b10
   } iecd_state_t;
endpackage : iecd_pkg
